// [hw/async_read_pkg.sv]
// Package for the asynchronous memory read strobe timing block.
// Holds phase widths, reset values and cycle counts shared by the design.
package async_read_pkg;

  localparam int unsigned SYS_CLK_HZ     = 100_000_000;
  localparam int unsigned SYS_PERIOD_PS  = 10_000;

  // Widths of configuration counts and pins
  localparam int unsigned SETUP_W  = 4;
  localparam int unsigned STROBE_W = 6;
  localparam int unsigned HOLD_W   = 3;
  localparam int unsigned TURN_W   = 2;
  localparam int unsigned UNITS_W  = 8;
  localparam int unsigned ADDR_W   = 21;
  localparam int unsigned BANK_W   = 2;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned CS_W     = 4;
  localparam int unsigned CSSEL_W  = 2;
  localparam int unsigned CNT_W    = 6;
  localparam int unsigned SUB_W    = 4;
  localparam int unsigned LEN_W    = 14;

  // Last sub-count of one extended wait unit, which lasts sixteen system clocks
  localparam logic [SUB_W-1:0] UNIT_LAST = 4'hF;
  // Wait must be seen this many cycles before the plain strobe ends
  localparam logic [CNT_W-1:0] WAIT_LEAD_CYC = 6'h04;

  // Reset values
  localparam logic [CS_W-1:0]   CS_IDLE_N   = 4'hF;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 21'h000000;
  localparam logic [BANK_W-1:0] BANK_RESET  = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RESET  = 16'h0000;
  localparam logic [UNITS_W-1:0] UNITS_RESET = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_RESET   = 6'h00;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_EXTWAIT, ST_HOLD, ST_TURN
  } phase_e;

endpackage : async_read_pkg

// [hw/wait_input_sync.sv]
// Three-stage synchroniser with agreement filter for the memory wait pin.
// Assumes the pin is asynchronous to clk_sys; output is a clean level.
`timescale 1ns/1ps
module wait_input_sync
  import async_read_pkg::*;
(
  input  wire logic clk_sys,   // System clock
  input  wire logic rst_n,     // Async reset, active low
  input  wire logic pinIn,     // Raw wait pin
  output logic      levelOut   // Filtered wait level
);

  logic stage1_q, stage2_q, stage3_q, level_q;
  logic level_d;

  // Level changes only once the second and third stages agree
  always_comb begin
    level_d = level_q;
    if (stage2_q == stage3_q) begin
      level_d = stage3_q;
    end
  end

  // First stage feeds only the second, to keep metastability contained
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
      level_q  <= 1'b0;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q  <= level_d;
    end
  end

  assign levelOut = level_q;

endmodule : wait_input_sync

// [hw/async_memory_strobe_timing.sv]
// Read strobe sequencer for asynchronous memories (SRAM, parallel flash).
// Assumes requests come from logic on clk_sys; wait arrives from a pin.
// Operation
// R1 - All phase lengths are whole system clock periods, counted on clk_sys.
// R2 - Without extended wait, access lasts setup plus strobe plus hold cycles.
// R3 - With extended wait, access grows sixteen cycles per counted wait unit.
// R4 - Strobe falls setup cycles after select, or with select in strobe mode.
// R5 - Select stays low hold cycles after strobe rises, or rises with it.
// R6 - Bank and address are valid setup cycles before strobe falls.
// R7 - Bank and address stay unchanged hold cycles after strobe rises.
// R8 - Without extended wait, strobe is low exactly the strobe count.
// R9 - With extended wait, strobe low adds sixteen cycles per wait unit.
// R10 - Memory holds each wait level at least two system clock periods.
// R11 - Wait must appear four cycles before plain strobe end to extend.
// R12 - Wait deadline is measured to the unextended hold start.
// R13 - Wait units are counted while wait stays asserted after strobe.
// R14 - Waiting stops when units reach the programmed maximum limit.
// R15 - Programmable turnaround cycles separate accesses; counts are inputs.
// R16 - Read data is captured as the strobe rises.
`timescale 1ns/1ps
module async_memory_strobe_timing
  import async_read_pkg::*;
(
  input  wire logic                clk_sys,               // System clock
  input  wire logic                rst_n,                 // Async reset
  input  wire logic                readReq,               // Start read pulse
  input  wire logic [ADDR_W-1:0]   readAddr,              // Word address
  input  wire logic [BANK_W-1:0]   readBank,              // Bank select
  input  wire logic [CSSEL_W-1:0]  chipIndex,             // Which select
  input  wire logic [SETUP_W-1:0]  read_setup_count,      // Setup cycles
  input  wire logic [STROBE_W-1:0] readStrobeCount,       // Strobe cycles
  input  wire logic [HOLD_W-1:0]   read_hold_count,       // Hold cycles
  input  wire logic [TURN_W-1:0]   turnaround_count,      // Gap cycles
  input  wire logic [UNITS_W-1:0]  max_wait_limit,        // Unit timeout
  input  wire logic                extended_wait_enable,  // Honour wait
  input  wire logic                selectStrobeMode,      // Select=strobe
  input  wire logic                memory_wait_input,     // Wait pin
  input  wire logic [DATA_W-1:0]   external_data_bus,     // Data pin in
  output logic                     read_strobe_n,         // Output enable
  output logic [CS_W-1:0]          async_chip_select_n,   // Selects
  output logic [BANK_W-1:0]        bank_select_lines,     // Bank pins
  output logic [ADDR_W-1:0]        external_address_lines,// Address pins
  output logic [DATA_W-1:0]        readData,              // Captured data
  output logic                     readDone,              // Done pulse
  output logic                     readTimeout,           // Timeout pulse
  output logic [UNITS_W-1:0]       extended_wait_units,   // Last unit count
  output logic                     busy                   // Not idle
);

  phase_e               state_q, state_d;
  logic [CNT_W-1:0]     cnt_q, cnt_d;
  logic [SUB_W-1:0]     sub_q, sub_d;
  logic [UNITS_W-1:0]   units_q, units_d;
  logic                 waitHit_q, waitHit_d;
  logic [SETUP_W-1:0]   setupCnt_q, setupCnt_d;
  logic [STROBE_W-1:0]  rst_q, rst_d;
  logic [HOLD_W-1:0]    holdCnt_q, holdCnt_d;
  logic [TURN_W-1:0]    turnCnt_q, turnCnt_d;
  logic [UNITS_W-1:0]   max_q, max_d;
  logic                 extWait_q, extWait_d, ss_q, ss_d;
  logic [CSSEL_W-1:0]   sel_q, sel_d;
  logic [ADDR_W-1:0]    addr_q, addr_d;
  logic [BANK_W-1:0]    bank_q, bank_d;
  logic [DATA_W-1:0]    data_q, data_d;
  logic                 oeN_q, oeN_d, done_q, done_d, tmo_q, tmo_d;
  logic [CS_W-1:0]      csN_q, csN_d;
  logic                 waitSeen;
  logic                 busy_q, busy_d;

  // Zero counts are stretched to one cycle so setup, strobe and hold always exist
  function automatic logic [CNT_W-1:0] lastCyc(input logic [CNT_W-1:0] n);
    lastCyc = (n == CNT_RESET) ? CNT_RESET : n - 6'h01;
  endfunction : lastCyc

  wait_input_sync wait_input_sync_i (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pinIn    (memory_wait_input),
    .levelOut (waitSeen)
  );

  // Phase sequencer: every phase counted in clk_sys cycles [R1]
  always_comb begin
    state_d = state_q;   cnt_d = cnt_q;     sub_d = sub_q;
    units_d = units_q;   waitHit_d = waitHit_q;
    setupCnt_d = setupCnt_q;   rst_d = rst_q;
    holdCnt_d = holdCnt_q;     turnCnt_d = turnCnt_q;
    max_d = max_q; extWait_d = extWait_q;   ss_d = ss_q;   sel_d = sel_q;
    addr_d = addr_q;     bank_d = bank_q;    data_d = data_q;
    done_d = 1'b0;       tmo_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (readReq) begin
          // Config latched per access so mid-access changes are harmless
          setupCnt_d = read_setup_count;                        // [R15]
          rst_d = readStrobeCount;
          holdCnt_d = read_hold_count;
          turnCnt_d = turnaround_count;
          max_d = max_wait_limit;    extWait_d = extended_wait_enable;
          ss_d = selectStrobeMode;   sel_d = chipIndex;
          addr_d = readAddr;         bank_d = readBank;         // [R6]
          units_d = UNITS_RESET;     waitHit_d = 1'b0;
          cnt_d = lastCyc(CNT_W'(read_setup_count));
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_q == CNT_RESET) begin
          cnt_d = lastCyc(CNT_W'(rst_q));
          state_d = ST_STROBE;                                   // [R4]
        end else begin
          cnt_d = cnt_q - 6'h01;
        end
      end
      ST_STROBE: begin
        // Deadline judged against the plain strobe end only [R11] [R12]
        if (extWait_q && waitSeen && (cnt_q >= WAIT_LEAD_CYC - 6'h01)) begin
          waitHit_d = 1'b1;
        end
        if (cnt_q == CNT_RESET) begin
          if (waitHit_q) begin
            units_d = 8'h01;                                     // [R13]
            sub_d = UNIT_LAST;
            state_d = ST_EXTWAIT;
          end else begin
            data_d = external_data_bus;                          // [R16]
            cnt_d = lastCyc(CNT_W'(holdCnt_q));
            state_d = ST_HOLD;                                   // [R8]
          end
        end else begin
          cnt_d = cnt_q - 6'h01;
        end
      end
      ST_EXTWAIT: begin
        if (sub_q == 4'h0) begin
          // Whole units only, so the stretch is a multiple of 16 [R3] [R9]
          if (units_q >= max_q) begin
            tmo_d = 1'b1;                                        // [R14]
            data_d = external_data_bus;
            cnt_d = lastCyc(CNT_W'(holdCnt_q));
            state_d = ST_HOLD;
          end else if (waitSeen) begin
            units_d = units_q + 8'h01;                           // [R13]
            sub_d = UNIT_LAST;
          end else begin
            data_d = external_data_bus;                          // [R16]
            cnt_d = lastCyc(CNT_W'(holdCnt_q));
            state_d = ST_HOLD;
          end
        end else begin
          sub_d = sub_q - 4'h1;
        end
      end
      ST_HOLD: begin
        if (cnt_q == CNT_RESET) begin
          done_d = 1'b1;                                         // [R2]
          if (turnCnt_q == 2'h0) begin
            state_d = ST_IDLE;
          end else begin
            cnt_d = lastCyc(CNT_W'(turnCnt_q));
            state_d = ST_TURN;                                   // [R15]
          end
        end else begin
          cnt_d = cnt_q - 6'h01;                                 // [R7]
        end
      end
      ST_TURN: begin
        if (cnt_q == CNT_RESET) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 6'h01;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Pin levels follow the next phase so they leave a flop each cycle
  always_comb begin
    logic strobing;
    logic active;
    strobing = (state_d == ST_STROBE) || (state_d == ST_EXTWAIT);
    active   = (state_d != ST_IDLE) && (state_d != ST_TURN);
    oeN_d    = !strobing;
    busy_d   = (state_d != ST_IDLE);  // Flopped so busy is a clean output
    csN_d    = CS_IDLE_N;
    // Strobe mode drops select only with the strobe [R4] [R5]
    if (ss_d ? strobing : active) begin
      csN_d[sel_d] = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;   cnt_q <= CNT_RESET;  sub_q <= 4'h0;
      units_q <= UNITS_RESET;  waitHit_q <= 1'b0;
      setupCnt_q <= 4'h0;  rst_q <= 6'h00;  holdCnt_q <= 3'h0;
      turnCnt_q <= 2'h0;  max_q <= 8'h00;  extWait_q <= 1'b0;
      ss_q <= 1'b0;  sel_q <= 2'h0;  busy_q <= 1'b0;
      addr_q <= ADDR_RESET;  bank_q <= BANK_RESET;  data_q <= DATA_RESET;
      oeN_q <= 1'b1;  csN_q <= CS_IDLE_N;  done_q <= 1'b0;  tmo_q <= 1'b0;
    end else begin
      state_q <= state_d;   cnt_q <= cnt_d;      sub_q <= sub_d;
      units_q <= units_d;   waitHit_q <= waitHit_d;
      setupCnt_q <= setupCnt_d;  rst_q <= rst_d;  holdCnt_q <= holdCnt_d;
      turnCnt_q <= turnCnt_d;  max_q <= max_d;  extWait_q <= extWait_d;
      ss_q <= ss_d;  sel_q <= sel_d;  busy_q <= busy_d;
      addr_q <= addr_d;  bank_q <= bank_d;  data_q <= data_d;
      oeN_q <= oeN_d;  csN_q <= csN_d;  done_q <= done_d;  tmo_q <= tmo_d;
    end
  end

  assign read_strobe_n          = oeN_q;
  assign async_chip_select_n    = csN_q;
  assign bank_select_lines      = bank_q;
  assign external_address_lines = addr_q;
  assign readData               = data_q;
  assign readDone               = done_q;
  assign readTimeout            = tmo_q;
  assign extended_wait_units    = units_q;
  assign busy                   = busy_q;

  // Helper counters measuring strobe, select and access lengths
  logic [LEN_W-1:0] oeLen_q, csLen_q, accLen_q;
  logic [LEN_W-1:0] expOe, expAcc, setupLen, strobeLen, holdLen;
  logic [DATA_W-1:0] busPrev_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oeLen_q <= '0;  csLen_q <= '0;  accLen_q <= '0;  busPrev_q <= '0;
    end else begin
      oeLen_q   <= oeN_q ? '0 : oeLen_q + 14'h0001;
      csLen_q   <= (&csN_q) ? '0 : csLen_q + 14'h0001;
      accLen_q  <= (state_d == ST_IDLE || state_d == ST_TURN) ? '0 :
                   accLen_q + 14'h0001;
      busPrev_q <= external_data_bus;
    end
  end
  // Zero counts run as one cycle, so the checks clamp them the same way
  assign setupLen  = (setupCnt_q == 4'h0) ? 14'h0001 : LEN_W'(setupCnt_q);
  assign strobeLen = (rst_q == 6'h00) ? 14'h0001 : LEN_W'(rst_q);
  assign holdLen   = (holdCnt_q == 3'h0) ? 14'h0001 : LEN_W'(holdCnt_q);
  assign expOe  = strobeLen + LEN_W'({units_q, 4'h0});
  assign expAcc = expOe + setupLen + holdLen;

  // Counters already hold the full low run at the edge that ends it
  a_strobe_plain: assert property ( // [R8]
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(oeN_q) && !extWait_q |-> oeLen_q == strobeLen)
    else $error("strobe width differs from strobe count");
  a_strobe_ext: assert property ( // [R9]
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(oeN_q) && extWait_q |-> oeLen_q == expOe)
    else $error("extended strobe width wrong");
  a_access_len: assert property ( // [R2]
    @(posedge clk_sys) disable iff (!rst_n)
    done_q |-> $past(accLen_q) == expAcc)
    else $error("access length wrong");
  a_setup_gap: assert property ( // [R4]
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(oeN_q) && !ss_q |-> csLen_q == setupLen)
    else $error("select to strobe setup wrong");
  a_select_with: assert property ( // [R5]
    @(posedge clk_sys) disable iff (!rst_n)
    ss_q && busy_q |-> (oeN_q == (&csN_q)))
    else $error("select not tied to strobe");
  a_hold_stable: assert property ( // [R7]
    @(posedge clk_sys) disable iff (!rst_n)
    state_q == ST_HOLD && $past(state_q) == ST_HOLD
    |-> $stable(external_address_lines) && $stable(bank_select_lines))
    else $error("address moved during hold");
  a_timeout_at: assert property ( // [R14]
    @(posedge clk_sys) disable iff (!rst_n)
    tmo_q |-> units_q == max_q || (max_q == 8'h00 && units_q == 8'h01))
    else $error("timeout not at limit");
  a_no_extend: assert property ( // [R11]
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(oeN_q) && !waitHit_q |-> units_q == UNITS_RESET)
    else $error("extension without early wait");
  a_data_latch: assert property ( // [R16]
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(oeN_q) |-> readData == busPrev_q)
    else $error("data not captured at strobe rise");

endmodule : async_memory_strobe_timing

// [test/async_mem_model.sv]
// Behavioural asynchronous memory facing the read strobe sequencer.
// Assumes strobe, selects and address are driven from clk_sys flops.
`timescale 1ns/1ps
module async_mem_model
  import async_read_pkg::*;
(
  input  wire logic              clk_sys,     // System clock
  input  wire logic              rst_n,       // Async reset
  input  wire logic              strobeN,     // Output enable
  input  wire logic [CS_W-1:0]   selN,        // Selects
  input  wire logic [ADDR_W-1:0] addr,        // Address
  input  wire logic [7:0]        waitUnits,   // Units to hold wait
  input  wire logic              lateWait,    // Raise wait too late
  input  wire logic [6:0]        plainStrobe, // Unextended strobe
  output logic                   waitPin,     // Wait to device
  output logic [DATA_W-1:0]      dataBus      // Read data
);
  logic [11:0] cnt_q;
  logic [1:0]  late_q;
  logic        wait_q;
  logic [15:0] junk_q;

  // Wait profile follows the strobe-low cycle count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 12'h000;
      late_q <= 2'h0;
      wait_q <= 1'b0;
      junk_q <= 16'h0000;
    end else begin
      cnt_q  <= strobeN ? 12'h000 : cnt_q + 12'h001;
      junk_q <= junk_q + 16'h3B5D; // Never rests on a stale value
      // Late pulse lasts three cycles, past the deadline
      if (late_q != 2'h0) late_q <= late_q - 2'h1;
      else if (lateWait && !strobeN &&
               cnt_q + 12'h001 == {5'h00, plainStrobe} - 12'h001)
        late_q <= 2'h3;
      // Early wait, dropped a few cycles into the last unit
      wait_q <= waitUnits != 8'h00 && !lateWait && !strobeN &&
                cnt_q + 12'h001 <= {5'h00, plainStrobe} + 12'h004 +
                12'h010 * ({4'h0, waitUnits} - 12'h001);
    end
  end

  assign waitPin = wait_q | (late_q != 2'h0);
  // Delay keeps data valid through the capture edge
  assign #1 dataBus = (!strobeN && selN != CS_IDLE_N) ?
                      addr[15:0] ^ 16'h5A3C : junk_q;
endmodule : async_mem_model

// [test/async_memory_strobe_timing_bench.sv]
// Self-checking bench for the asynchronous memory read strobe sequencer.
// Assumes the memory model answers data and wait on the pins.
`timescale 1ns/1ps
module async_memory_strobe_timing_bench
  import async_read_pkg::*;
();
  logic clk_sys, rst_n, readReq, readDone, readTimeout, busy;
  logic extended_wait_enable, selectStrobeMode, memory_wait_input;
  logic read_strobe_n, lateWait;
  logic [ADDR_W-1:0]   readAddr, external_address_lines;
  logic [BANK_W-1:0]   readBank, bank_select_lines;
  logic [CSSEL_W-1:0]  chipIndex;
  logic [SETUP_W-1:0]  read_setup_count;
  logic [STROBE_W-1:0] readStrobeCount;
  logic [HOLD_W-1:0]   read_hold_count;
  logic [TURN_W-1:0]   turnaround_count;
  logic [UNITS_W-1:0]  max_wait_limit, extended_wait_units, waitUnits;
  logic [DATA_W-1:0]   external_data_bus, readData;
  logic [CS_W-1:0]     async_chip_select_n;
  logic [6:0]          plainStrobe;
  logic [31:0]         seed, oeN, csN, setN, busyN, tmoN, busyExp;
  int                  n_mismatch, n_checks, i;
  typedef struct {
    logic [DATA_W-1:0] data;
    logic [CS_W-1:0]   sel;
    logic [ADDR_W-1:0] addr;
    logic [BANK_W-1:0] bank;
    logic [31:0]       setup, oeLow, csLow, busyLen, units, tmo;
  } note_s;
  note_s q[$];
  note_s cur;

  async_memory_strobe_timing async_memory_strobe_timing_i (
    .clk_sys, .rst_n, .readReq, .readAddr, .readBank, .chipIndex,
    .read_setup_count, .readStrobeCount, .read_hold_count,
    .turnaround_count, .max_wait_limit, .extended_wait_enable,
    .selectStrobeMode, .memory_wait_input, .external_data_bus,
    .read_strobe_n, .async_chip_select_n, .bank_select_lines,
    .external_address_lines, .readData, .readDone, .readTimeout,
    .extended_wait_units, .busy);
  async_mem_model async_mem_model_i (
    .clk_sys, .rst_n, .strobeN(read_strobe_n), .selN(async_chip_select_n),
    .addr(external_address_lines), .waitUnits, .lateWait, .plainStrobe,
    .waitPin(memory_wait_input), .dataBus(external_data_bus));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Zero counts behave as one cycle
  function automatic logic [31:0] cl(input logic [31:0] v);
    return (v == 0) ? 32'h1 : v;
  endfunction : cl

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // One read; caller stands just after a rising edge
  task automatic rd(input logic ss, ew, input logic [7:0] un, lim,
                    input logic late, input logic [5:0] st, input logic sp);
    note_s n;
    logic [31:0] r, su, hd, sw, u;
    int k;
    seed = lfsr(seed);
    r = seed;
    seed = lfsr(seed);
    su = cl(r[3:0]);
    hd = cl(r[6:4]);
    sw = cl((st != 0) ? st : r[12:7]);
    u = (!ew || late) ? 0 : ((un > cl(lim)) ? cl(lim) : un);
    n.tmo = ew && !late && un > cl(lim);
    n.addr = seed[20:0];
    n.bank = seed[22:21];
    n.sel = ~(4'h1 << seed[24:23]);
    n.data = seed[15:0] ^ 16'h5A3C;
    n.oeLow = sw + 16 * u;
    n.setup = ss ? 0 : su;
    n.csLow = ss ? n.oeLow : su + n.oeLow + hd;
    n.busyLen = su + n.oeLow + hd + r[14:13];
    n.units = u;
    readReq <= 1'b1;
    readAddr <= seed[20:0];
    readBank <= seed[22:21];
    chipIndex <= seed[24:23];
    read_setup_count <= r[3:0];
    readStrobeCount <= (st != 0) ? st : r[12:7];
    read_hold_count <= r[6:4];
    turnaround_count <= r[14:13];
    max_wait_limit <= lim;
    extended_wait_enable <= ew;
    selectStrobeMode <= ss;
    waitUnits <= un;
    lateWait <= late;
    plainStrobe <= sw[6:0];
    q.push_back(n);
    k = 0;
    // Stray request mid-access must be dropped
    do begin
      @(posedge clk_sys);
      k++;
      if (busy !== 1'b0 || k == 1) readReq <= sp && k == 4;
    end while ((busy !== 1'b0 || k == 1) && k < 3000);
  endtask : rd

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Pin watcher: counts phase cycles, compares at each done pulse
  always @(negedge clk_sys) begin
    if (!rst_n) begin
      {oeN, csN, setN, busyN, tmoN} = '0;
      q.delete();
    end else begin
      if (async_chip_select_n !== CS_IDLE_N && q.size() > 0) begin
        csN++;
        if (read_strobe_n === 1'b1 && oeN == 0) setN++;
        chk(async_chip_select_n, q[0].sel);
        chk(external_address_lines, q[0].addr);
        chk(bank_select_lines, q[0].bank);
      end
      if (read_strobe_n === 1'b0) oeN++;
      if (busy === 1'b1) busyN++;
      if (readTimeout === 1'b1) tmoN++;
      if (readDone === 1'b1) begin
        chk(q.size() != 0, 1);
        if (q.size() > 0) begin
          cur = q.pop_front();
          chk(readData, cur.data);
          chk(oeN, cur.oeLow);
          chk(csN, cur.csLow);
          chk(setN, cur.setup);
          chk(extended_wait_units, cur.units);
          chk(tmoN, cur.tmo);
          busyExp = cur.busyLen;
        end
        {oeN, csN, setN, tmoN} = '0;
      end
      if (busy === 1'b0 && busyN != 0) begin
        chk(busyN, busyExp);
        busyN = 0;
      end
    end
  end

  // Watchdog at 30000 cycles, well beyond the fewer than two thousand the tests need
  initial begin
    #300000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    seed = 32'h4862;
    {rst_n, readReq, extended_wait_enable, selectStrobeMode} = '0;
    {readAddr, readBank, chipIndex, read_setup_count} = '0;
    {readStrobeCount, read_hold_count, turnaround_count} = '0;
    {max_wait_limit, waitUnits, lateWait} = '0;
    plainStrobe = 7'h01;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (i = 0; i < 8; i++) begin
      rd(i[0], 0, 0, 8, 0, (i == 2) ? 12 : 0, i == 2);
    end
    rd(0, 0, 2, 8, 0, 12, 0);
    rd(0, 1, 1, 8, 0, 12, 0);
    rd(1, 1, 2, 8, 0, 12, 0);
    rd(0, 1, 1, 8, 1, 12, 0);
    rd(1, 1, 3, 1, 0, 12, 0);
    rd(0, 1, 3, 0, 0, 12, 0);
    readReq <= 1'b1;
    @(posedge clk_sys);
    readReq <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(0, 0, 0, 8, 0, 0, 0);
    repeat (8) @(posedge clk_sys);
    chk(q.size(), 0);
    complete_run();
  end
endmodule : async_memory_strobe_timing_bench
